// ### core/efp_encoder_feedback.sv
// Encoder feedback decoder, position validation and stall detection with APB registers.
//
// Functional notes
// RULE1: Encoder type is none, quadrature or up/down.
// RULE2: Type none never flags stall, positions meaningless.
// RULE3: Quadrature or up/down updates encoder position words.
// RULE4: Quadrature counts up when A leads B.
// RULE5: Quadrature counts at twice or four times rate.
// RULE6: Marker input may serve as origin reference.
// RULE7: Up/down: A pulses count up, B down.
// RULE8: Multiplier 1 to 255, divisor 1 to 16.
// RULE9: Multiplier over divisor relates steps to encoder pulses.
// RULE10: Zero tolerance disables position validation.
// RULE11: Difference above tolerance clears position valid flag.
// RULE12: Validation failure never halts the running move.
// RULE13: Feedback below ten percent velocity means stall.
// RULE14: Encoder pins synchronised and filtered before edges.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module efp_encoder_feedback
    import efp_pkg::*;
#(
    parameter int STALL_WIN_CYC = EFP_STALL_WIN_CYC,
    parameter int FILT_CYC      = EFP_FILT_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Encoder pins
    input  wire logic        enc_a_pin,
    input  wire logic        enc_b_pin,
    input  wire logic        enc_marker_pin,
    // Step generator side, same clock
    input  wire logic        step_pulse,
    input  wire logic        step_dir_up,
    input  wire logic        find_origin_active,
    // Status outputs
    output logic             position_valid_flag,
    output logic             motor_stalled_error_flag,
    output logic             step_inhibit,
    output logic             irq
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (STALL_WIN_CYC < 16 || STALL_WIN_CYC > 65535) begin : g_chk_win
        $error("STALL_WIN_CYC out of range");
    end
    if (FILT_CYC < 1 || FILT_CYC > 255) begin : g_chk_filt
        $error("FILT_CYC out of range");
    end

    function automatic logic [EFP_WIDE_W-1:0] abs_wide(input logic signed [EFP_WIDE_W-1:0] v);
        abs_wide = v[EFP_WIDE_W-1] ? (EFP_WIDE_W)'(-v) : v;
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    efp_ctrl_t                 ctrl_ff;
    logic [EFP_MULT_W-1:0]     mult_ff;
    logic [EFP_DIV_W-1:0]      div_ff;
    logic [EFP_TOL_W-1:0]      tol_ff;
    logic [EFP_INT_W-1:0]      int_stat_ff;
    logic [EFP_INT_W-1:0]      int_mask_ff;
    logic signed [EFP_POS_W-1:0] enc_pos_ff;
    logic signed [EFP_POS_W-1:0] mot_pos_ff;
    logic                      valid_ff;
    logic                      stall_ff;
    logic                      irq_ff;
    logic [31:0]               prdata_ff;
    logic                      pready_ff;
    logic                      pslverr_ff;

    logic setup;
    logic wr_en;
    logic addr_hit;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pready_ff & pwrite;

    always_comb begin
        case (paddr)
            EFP_OFS_CTRL, EFP_OFS_RATIO, EFP_OFS_TOL, EFP_OFS_SETPOS,
            EFP_OFS_MPOS_LO, EFP_OFS_MPOS_HI, EFP_OFS_EPOS_LO, EFP_OFS_EPOS_HI,
            EFP_OFS_STATUS, EFP_OFS_INT_STAT, EFP_OFS_INT_MASK, EFP_OFS_CLEAR: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // The slave answers in the first access cycle; the read word is latched at setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= setup;
            pslverr_ff <= setup & ~addr_hit;
            if (setup && !pwrite) begin
                case (paddr)
                    EFP_OFS_CTRL:     prdata_ff <= 32'(ctrl_ff);
                    EFP_OFS_RATIO:    prdata_ff <= {19'h0, div_ff, mult_ff};
                    EFP_OFS_TOL:      prdata_ff <= 32'(tol_ff);
                    EFP_OFS_MPOS_LO:  prdata_ff <= 32'(mot_pos_ff[EFP_WORD_W-1:0]);
                    EFP_OFS_MPOS_HI:  prdata_ff <= 32'(mot_pos_ff[EFP_POS_W-1:EFP_WORD_W]);
                    EFP_OFS_EPOS_LO:  prdata_ff <= 32'(enc_pos_ff[EFP_WORD_W-1:0]);
                    EFP_OFS_EPOS_HI:  prdata_ff <= 32'(enc_pos_ff[EFP_POS_W-1:EFP_WORD_W]);
                    EFP_OFS_STATUS:   prdata_ff <= {30'h0, stall_ff, valid_ff};
                    EFP_OFS_INT_STAT: prdata_ff <= 32'(int_stat_ff);
                    EFP_OFS_INT_MASK: prdata_ff <= 32'(int_mask_ff);
                    default:          prdata_ff <= 32'h0000_0000;
                endcase
            end else if (setup) begin
                prdata_ff <= 32'h0000_0000;
            end
        end
    end

    // Out-of-range multiplier or divisor writes are clamped into the legal range.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff     <= EFP_CTRL_RST;
            mult_ff     <= EFP_MULT_RST;
            div_ff      <= EFP_DIV_RST;
            tol_ff      <= EFP_TOL_RST;
            int_mask_ff <= '0;
        end else if (wr_en) begin
            case (paddr)
                EFP_OFS_CTRL: begin
                    ctrl_ff <= efp_ctrl_t'(pwdata[EFP_CTRL_W-1:0]);
                    if (pwdata[$bits(efp_enc_type_t)-1:0] == 2'h3) begin
                        ctrl_ff.enc_type <= EFP_ENC_NONE;  // [RULE1]
                    end
                end
                EFP_OFS_RATIO: begin
                    mult_ff <= (pwdata[EFP_MULT_W-1:0] == 8'h00) ? EFP_MULT_RST
                                                                : pwdata[EFP_MULT_W-1:0];  // [RULE8]
                    if (pwdata[EFP_DIV_LSB +: EFP_DIV_W] == 5'h00) begin
                        div_ff <= EFP_DIV_RST;  // [RULE8]
                    end else if (pwdata[EFP_DIV_LSB +: EFP_DIV_W] > EFP_DIV_MAX) begin
                        div_ff <= EFP_DIV_MAX;  // [RULE8]
                    end else begin
                        div_ff <= pwdata[EFP_DIV_LSB +: EFP_DIV_W];
                    end
                end
                EFP_OFS_TOL:      tol_ff      <= pwdata[EFP_TOL_W-1:0];
                EFP_OFS_INT_MASK: int_mask_ff <= pwdata[EFP_INT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Encoder input synchroniser and filter
    // ****************************************************************
    efp_enc_pins_t pin_s1_ff;
    efp_enc_pins_t pin_s2_ff;
    efp_enc_pins_t filt_ff;
    efp_enc_pins_t filt_d_ff;
    logic [7:0]    filt_cnt_ff [3];

    // A level is accepted only after it has stood for FILT_CYC cycles, so
    // contact bounce and line noise cannot produce extra counts.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            filt_ff   <= '0;
            filt_d_ff <= '0;
            for (int i = 0; i < 3; i++) begin
                filt_cnt_ff[i] <= 8'h00;
            end
        end else begin
            pin_s1_ff <= '{enc_marker_pin, enc_b_pin, enc_a_pin};  // [RULE14]
            pin_s2_ff <= pin_s1_ff;  // [RULE14]
            filt_d_ff <= filt_ff;
            for (int i = 0; i < 3; i++) begin
                if (pin_s2_ff[i] == filt_ff[i]) begin
                    filt_cnt_ff[i] <= 8'h00;
                end else if (filt_cnt_ff[i] == 8'(FILT_CYC - 1)) begin
                    filt_cnt_ff[i] <= 8'h00;
                    filt_ff[i]     <= pin_s2_ff[i];  // [RULE14]
                end else begin
                    filt_cnt_ff[i] <= filt_cnt_ff[i] + 8'h01;
                end
            end
        end
    end

    // ****************************************************************
    // Decoder
    // ****************************************************************
    logic edge_a;
    logic edge_b;
    logic cnt_up;
    logic cnt_dn;
    logic marker_rise;
    assign edge_a      = filt_ff.a ^ filt_d_ff.a;
    assign edge_b      = filt_ff.b ^ filt_d_ff.b;
    assign marker_rise = filt_ff.marker & ~filt_d_ff.marker;

    always_comb begin
        cnt_up = 1'b0;
        cnt_dn = 1'b0;
        case (ctrl_ff.enc_type)
            EFP_ENC_QUAD: begin
                // Simultaneous edges on both channels carry no direction and are dropped.
                if (edge_a && !edge_b) begin
                    cnt_up = filt_ff.a != filt_ff.b;  // [RULE4]
                    cnt_dn = filt_ff.a == filt_ff.b;  // [RULE4]
                end else if (edge_b && !edge_a && ctrl_ff.quad_x4) begin
                    cnt_up = filt_ff.a == filt_ff.b;  // [RULE5]
                    cnt_dn = filt_ff.a != filt_ff.b;  // [RULE5]
                end
            end
            EFP_ENC_UPDOWN: begin
                cnt_up = filt_ff.a & ~filt_d_ff.a & ~(filt_ff.b & ~filt_d_ff.b);  // [RULE7]
                cnt_dn = filt_ff.b & ~filt_d_ff.b & ~(filt_ff.a & ~filt_d_ff.a);  // [RULE7]
            end
            default: begin
            end
        endcase
    end

    // ****************************************************************
    // Positions, origin and validation
    // ****************************************************************
    logic origin_hit;
    logic setpos_wr;
    logic viol;
    logic signed [EFP_WIDE_W-1:0] enc_scaled;
    logic signed [EFP_WIDE_W-1:0] mot_scaled;
    logic [EFP_WIDE_W-1:0]        tol_scaled;

    assign origin_hit = ctrl_ff.origin_marker & find_origin_active & marker_rise
                        & (ctrl_ff.enc_type != EFP_ENC_NONE);  // [RULE6]
    assign setpos_wr  = wr_en & (paddr == EFP_OFS_SETPOS);

    // Encoder count times multiplier against motor count times divisor keeps the
    // ratio exact without a divider.
    assign enc_scaled = EFP_WIDE_W'(enc_pos_ff) * $signed({1'b0, mult_ff});  // [RULE9]
    assign mot_scaled = EFP_WIDE_W'(mot_pos_ff) * $signed({1'b0, div_ff});  // [RULE9]
    assign tol_scaled = EFP_WIDE_W'(tol_ff) * EFP_WIDE_W'(div_ff);
    assign viol = (tol_ff != EFP_TOL_RST) && (ctrl_ff.enc_type != EFP_ENC_NONE)
                  && (abs_wide(enc_scaled - mot_scaled) > tol_scaled);  // [RULE10] [RULE11]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enc_pos_ff <= '0;
            mot_pos_ff <= '0;
        end else if (setpos_wr) begin
            enc_pos_ff <= $signed(pwdata);
            mot_pos_ff <= $signed(pwdata);
        end else if (origin_hit) begin
            enc_pos_ff <= '0;  // [RULE6]
            mot_pos_ff <= '0;  // [RULE6]
        end else begin
            if (cnt_up) begin
                enc_pos_ff <= enc_pos_ff + 32'sh1;  // [RULE3]
            end else if (cnt_dn) begin
                enc_pos_ff <= enc_pos_ff - 32'sh1;  // [RULE3]
            end
            if (step_pulse) begin
                mot_pos_ff <= step_dir_up ? mot_pos_ff + 32'sh1 : mot_pos_ff - 32'sh1;
            end
        end
    end

    // Only the flag drops here; the move keeps running and software decides.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_ff <= 1'b0;
        end else if (setpos_wr || origin_hit) begin
            valid_ff <= 1'b1;
        end else if (viol) begin
            valid_ff <= 1'b0;  // [RULE11] [RULE12]
        end
    end

    // ****************************************************************
    // Stall detection
    // ****************************************************************
    logic [15:0] win_cnt_ff;
    logic [15:0] win_steps_ff;
    logic [15:0] win_enc_ff;
    logic        win_end;
    logic        stall_hit;
    logic        stall_clr;
    assign win_end   = win_cnt_ff == 16'(STALL_WIN_CYC - 1);
    assign stall_clr = wr_en & (paddr == EFP_OFS_CLEAR) & pwdata[EFP_CLR_STALL];
    // Measured steps are enc*mult/div; a stall is fewer than a tenth of the steps sent.
    assign stall_hit = win_end & ctrl_ff.stall_en & (ctrl_ff.enc_type != EFP_ENC_NONE)
                       & (win_steps_ff != 16'h0000)
                       & (32'(win_enc_ff) * 32'(mult_ff) * 32'(EFP_STALL_PCT_DEN)
                          < 32'(win_steps_ff) * 32'(div_ff));  // [RULE13] [RULE9] [RULE2]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt_ff   <= 16'h0000;
            win_steps_ff <= 16'h0000;
            win_enc_ff   <= 16'h0000;
        end else if (win_end) begin
            win_cnt_ff   <= 16'h0000;
            win_steps_ff <= 16'h0000;
            win_enc_ff   <= 16'h0000;
        end else begin
            win_cnt_ff <= win_cnt_ff + 16'h0001;
            if (step_pulse && win_steps_ff != 16'hffff) begin
                win_steps_ff <= win_steps_ff + 16'h0001;
            end
            if ((cnt_up || cnt_dn) && win_enc_ff != 16'hffff) begin
                win_enc_ff <= win_enc_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stall_ff <= 1'b0;
        end else if (stall_hit) begin
            stall_ff <= 1'b1;  // [RULE13]
        end else if (stall_clr || ctrl_ff.enc_type == EFP_ENC_NONE) begin
            stall_ff <= 1'b0;  // [RULE2]
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [EFP_INT_W-1:0] int_evt;
    logic [EFP_INT_W-1:0] int_clr;
    always_comb begin
        int_evt                     = '0;
        int_evt[EFP_INT_VALID_LOST] = valid_ff & viol & ~setpos_wr & ~origin_hit;
        int_evt[EFP_INT_STALL]      = stall_hit & ~stall_ff;
        int_evt[EFP_INT_ORIGIN]     = origin_hit & ~setpos_wr;
        int_clr = (wr_en && paddr == EFP_OFS_INT_STAT) ? pwdata[EFP_INT_W-1:0] : '0;
    end

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_ff <= '0;
            irq_ff      <= 1'b0;
        end else begin
            int_stat_ff <= (int_stat_ff & ~int_clr) | int_evt;
            irq_ff      <= |(((int_stat_ff & ~int_clr) | int_evt) & int_mask_ff);
        end
    end

    assign prdata                   = prdata_ff;
    assign pready                   = pready_ff;
    assign pslverr                  = pslverr_ff;
    assign position_valid_flag      = valid_ff;
    assign motor_stalled_error_flag = stall_ff;
    assign step_inhibit             = stall_ff;  // [RULE13]
    assign irq                      = irq_ff;

endmodule

`default_nettype wire

// ### core/efp_pkg.sv
// Package with register map, field layout and timing constants of the encoder feedback unit.
package efp_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [11:0] EFP_OFS_CTRL     = 12'h000;
    localparam logic [11:0] EFP_OFS_RATIO    = 12'h004;
    localparam logic [11:0] EFP_OFS_TOL      = 12'h008;
    localparam logic [11:0] EFP_OFS_SETPOS   = 12'h00c;
    localparam logic [11:0] EFP_OFS_MPOS_LO  = 12'h010;
    localparam logic [11:0] EFP_OFS_MPOS_HI  = 12'h014;
    localparam logic [11:0] EFP_OFS_EPOS_LO  = 12'h018;
    localparam logic [11:0] EFP_OFS_EPOS_HI  = 12'h01c;
    localparam logic [11:0] EFP_OFS_STATUS   = 12'h020;
    localparam logic [11:0] EFP_OFS_INT_STAT = 12'h024;
    localparam logic [11:0] EFP_OFS_INT_MASK = 12'h028;
    localparam logic [11:0] EFP_OFS_CLEAR    = 12'h02c;

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int          EFP_CTRL_W     = 5;
    localparam int          EFP_MULT_W     = 8;
    localparam int          EFP_DIV_W      = 5;
    localparam int          EFP_DIV_LSB    = 8;
    localparam int          EFP_TOL_W      = 8;
    localparam int          EFP_POS_W      = 32;
    localparam int          EFP_WORD_W     = 16;
    localparam int          EFP_INT_W      = 3;
    localparam int          EFP_WIDE_W     = 48;
    localparam logic [7:0]  EFP_MULT_RST   = 8'h01;
    localparam logic [4:0]  EFP_DIV_RST    = 5'h01;
    localparam logic [4:0]  EFP_DIV_MAX    = 5'h10;
    localparam logic [7:0]  EFP_TOL_RST    = 8'h00;

    // Interrupt status bits.
    localparam int EFP_INT_VALID_LOST = 0;
    localparam int EFP_INT_STALL      = 1;
    localparam int EFP_INT_ORIGIN     = 2;

    // Status register bits.
    localparam int EFP_ST_VALID = 0;
    localparam int EFP_ST_STALL = 1;

    // Clear register bits.
    localparam int EFP_CLR_STALL = 0;

    typedef enum logic [1:0] {
        EFP_ENC_NONE   = 2'h0,
        EFP_ENC_QUAD   = 2'h1,
        EFP_ENC_UPDOWN = 2'h2
    } efp_enc_type_t;

    // Layout of the control register, bit 4 downward to enc_type in bits 1:0.
    typedef struct packed {
        logic          stall_en;
        logic          origin_marker;
        logic          quad_x4;
        efp_enc_type_t enc_type;
    } efp_ctrl_t;

    localparam efp_ctrl_t EFP_CTRL_RST = '{1'b0, 1'b0, 1'b0, EFP_ENC_NONE};

    // Filtered encoder inputs travel together.
    typedef struct packed {
        logic marker;
        logic b;
        logic a;
    } efp_enc_pins_t;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int EFP_CLK_PERIOD_NS = 25;
    localparam int EFP_STALL_WIN_NS  = 1000000;
    localparam int EFP_STALL_WIN_CYC = EFP_STALL_WIN_NS / EFP_CLK_PERIOD_NS;
    localparam int EFP_FILT_NS       = 100;
    localparam int EFP_FILT_CYC      = (EFP_FILT_NS + EFP_CLK_PERIOD_NS - 1) / EFP_CLK_PERIOD_NS;
    localparam int EFP_STALL_PCT_DEN = 10;

endpackage

// ### tb/efp_enc_model.sv
// Behavioural incremental encoder that drives the channel and marker pins.
`timescale 1ns/1ps
`default_nettype none
module efp_enc_model (
    // Clock
    input  wire logic pclk,
    // Encoder pins
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_mk
);
    // Quad levels stand hold+1 cycles, pulse and marker highs only hold cycles; the input filter needs at least FILT_CYC.
    int hold = 4;
    initial {enc_a, enc_b, enc_mk} = 3'h0;
    task automatic hold_lvl();
        repeat (hold) @(posedge pclk);
    endtask
    // Gray order 00,10,11,01 going up and the reverse going down.
    task automatic quad(input logic up, input int n);
        repeat (n) begin
            @(posedge pclk);
            if ((enc_a == enc_b) == up)
                enc_a <= ~enc_a;
            else
                enc_b <= ~enc_b;
            hold_lvl();
        end
    endtask
    // One channel at a time, never both.
    task automatic pulse(input logic up, input int n);
        repeat (n) begin
            @(posedge pclk);
            if (up)
                enc_a <= 1'b1;
            else
                enc_b <= 1'b1;
            hold_lvl();
            {enc_a, enc_b} <= 2'h0;
            hold_lvl();
        end
    endtask
    task automatic marker();
        @(posedge pclk);
        enc_mk <= 1'b1;
        hold_lvl();
        enc_mk <= 1'b0;
        hold_lvl();
    endtask
endmodule
`default_nettype wire

// ### tb/efp_encoder_feedback_chk.sv
// Port-level checker for the encoder feedback unit.
`timescale 1ns/1ps
`default_nettype none
module efp_fb_chk import efp_pkg::*; (
    // Clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    // Motion status
    input wire logic        find_origin_active,
    input wire logic        position_valid_flag,
    input wire logic        motor_stalled_error_flag,
    input wire logic        step_inhibit
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_acc;
    assign wr_acc = psel && penable && pready && pwrite;
    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_inhibit_is_stall: assert property (step_inhibit == motor_stalled_error_flag)
        else $error("inhibit differs from stall");
    a_stall_sticky: assert property (motor_stalled_error_flag && !wr_acc |=> motor_stalled_error_flag)
        else $error("stall flag not held");
    a_stall_clear_cause: assert property ($fell(motor_stalled_error_flag) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("stall cleared without write");
    a_valid_rise_cause: assert property ($rose(position_valid_flag) |-> $past(wr_acc && paddr == EFP_OFS_SETPOS) || $past(find_origin_active))
        else $error("valid set without cause");
    a_valid_fall_setpos: assert property ($fell(position_valid_flag) |-> !$past(wr_acc && paddr == EFP_OFS_SETPOS))
        else $error("valid lost on set position");
    a_no_halt_invalid: assert property ($fell(position_valid_flag) |-> $stable(step_inhibit))
        else $error("validation loss stopped move");
    c_stall: cover property ($rose(motor_stalled_error_flag));
    c_valid_lost: cover property ($fell(position_valid_flag));
    c_valid_set: cover property ($rose(position_valid_flag));
endmodule
bind efp_encoder_feedback efp_fb_chk i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .find_origin_active(find_origin_active), .position_valid_flag(position_valid_flag),
    .motor_stalled_error_flag(motor_stalled_error_flag), .step_inhibit(step_inhibit));
`default_nettype wire

// ### tb/efp_encoder_feedback_bench.sv
// Self-checking bench of the encoder feedback unit.
`timescale 1ns/1ps
`default_nettype none
module efp_encoder_feedback_bench import efp_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic        step_pulse, fo_act, valid, stalled, inhibit, a, b, mk, dir_up;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic [31:0] ctl [3];
    int          err_total, checks, cyc, k;
    // Short window and filter keep the run brief.
    efp_encoder_feedback #(.STALL_WIN_CYC(64), .FILT_CYC(1)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .enc_a_pin(a), .enc_b_pin(b), .enc_marker_pin(mk),
        .step_pulse(step_pulse), .step_dir_up(dir_up), .find_origin_active(fo_act),
        .position_valid_flag(valid), .motor_stalled_error_flag(stalled),
        .step_inhibit(inhibit), .irq(irq));
    efp_enc_model i_enc (.pclk(pclk), .enc_a(a), .enc_b(b), .enc_mk(mk));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            stop_test();
        end
    end
    // ********
    // Helpers
    // ********
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Counts per move for ctl entries: quad x4, quad x2, up/down.
    function automatic logic [31:0] cnt(input int m, input int n);
        return (m == 1) ? 32'(n / 2) : 32'(n);
    endfunction
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rdpos(input logic [11:0] lo);
        logic [15:0] l;
        apb(1'b0, lo, 32'h0);
        l = rd[15:0];
        apb(1'b0, lo + 12'h4, 32'h0);
        rd = {rd[15:0], l};
    endtask
    task automatic steps(input int n);
        repeat (n) begin
            @(posedge pclk);
            step_pulse <= 1'b1;
            @(posedge pclk);
            step_pulse <= 1'b0;
        end
    endtask
    task automatic stop_test();
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    initial begin
        {presetn, psel, penable, pwrite, step_pulse, fo_act, dir_up} = 7'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        rnd = 32'h815d0e77;
        ctl = '{32'h5, 32'h1, 32'h2};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, EFP_OFS_RATIO, 32'h0);
        cmp(rd, 32'h101);
        apb(1'b0, 12'h030, 32'h0);
        cmp({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, EFP_OFS_RATIO, 32'h0);
        apb(1'b0, EFP_OFS_RATIO, 32'h0);
        cmp(rd, 32'h101);
        apb(1'b1, EFP_OFS_RATIO, 32'h1fff);
        apb(1'b0, EFP_OFS_RATIO, 32'h0);
        cmp(rd, 32'h10ff);
        apb(1'b1, EFP_OFS_CTRL, 32'h10);
        fork
            steps(40);
            i_enc.quad(1'b1, 8);
        join
        repeat (70) @(posedge pclk);
        cmp(32'(stalled), 32'h0);
        rdpos(EFP_OFS_EPOS_LO);
        cmp(rd, 32'h0);
        rdpos(EFP_OFS_MPOS_LO);
        cmp(rd, 32'hffff_ffd8);
        for (int m = 0; m < 3; m++) begin
            rnd = lfsr(rnd);
            k = 4 * (1 + rnd[1:0]);
            apb(1'b1, EFP_OFS_CTRL, ctl[m]);
            apb(1'b1, EFP_OFS_SETPOS, rnd);
            if (m == 2) i_enc.pulse(1'b1, k);
            else i_enc.quad(1'b1, k);
            repeat (8) @(posedge pclk);
            rdpos(EFP_OFS_EPOS_LO);
            cmp(rd, rnd + cnt(m, k));
            if (m == 2) i_enc.pulse(1'b0, k + 4);
            else i_enc.quad(1'b0, k + 4);
            repeat (8) @(posedge pclk);
            rdpos(EFP_OFS_EPOS_LO);
            cmp(rd, rnd - cnt(m, 4));
        end
        apb(1'b1, EFP_OFS_CTRL, 32'h5);
        apb(1'b1, EFP_OFS_RATIO, 32'h101);
        apb(1'b1, EFP_OFS_INT_MASK, 32'h7);
        apb(1'b1, EFP_OFS_SETPOS, 32'h0);
        i_enc.quad(1'b1, 8);
        repeat (8) @(posedge pclk);
        cmp(32'(valid), 32'h1);
        apb(1'b1, EFP_OFS_TOL, 32'h8);
        apb(1'b0, EFP_OFS_STATUS, 32'h0);
        cmp(rd, 32'h1);
        apb(1'b1, EFP_OFS_RATIO, 32'h102);
        apb(1'b0, EFP_OFS_INT_STAT, 32'h0);
        cmp(32'({rd[2:0], irq, valid, inhibit}), 32'hc);
        apb(1'b1, EFP_OFS_INT_STAT, 32'h7);
        @(posedge pclk);
        cmp(32'(irq), 32'h0);
        apb(1'b1, EFP_OFS_TOL, 32'h0);
        apb(1'b1, EFP_OFS_CTRL, 32'h15);
        apb(1'b1, EFP_OFS_SETPOS, 32'h0);
        rnd = lfsr(rnd);
        k = 10 + rnd[2:0];
        dir_up <= rnd[3];
        steps(k);
        rdpos(EFP_OFS_MPOS_LO);
        cmp(rd, rnd[3] ? 32'(k) : -32'(k));
        repeat (140) @(posedge pclk);
        cmp(32'({stalled, inhibit, irq}), 32'h7);
        apb(1'b1, EFP_OFS_CLEAR, 32'h1);
        @(posedge pclk);
        cmp(32'(stalled), 32'h0);
        apb(1'b1, EFP_OFS_INT_STAT, 32'h7);
        apb(1'b1, EFP_OFS_INT_MASK, 32'h3);
        apb(1'b1, EFP_OFS_CTRL, 32'hd);
        i_enc.quad(1'b1, 8);
        fo_act <= 1'b1;
        i_enc.marker();
        fo_act <= 1'b0;
        rdpos(EFP_OFS_EPOS_LO);
        cmp(rd, 32'h0);
        apb(1'b0, EFP_OFS_INT_STAT, 32'h0);
        cmp(32'({rd[2:0], irq}), 32'h8);
        stop_test();
    end
endmodule
`default_nettype wire
